// >>> common/sawd_pkg.sv
// Purpose: shared constants and types of the sleep-aware watchdog
// Assumes: 20 MHz bus clock, 31 kHz slow oscillator arriving as a pin
// Notes:   every offset, field position, reset value and count lives here
package sawd_pkg;

    // ********************************
    // clocks and time base
    // ********************************
    localparam int unsigned PCLK_HZ      = 20_000_000;
    localparam int unsigned OSC_HZ       = 31_000;
    localparam int unsigned BASE_TICK_US = 1_000;
    // slow oscillator edges per nominal 1 ms tick
    localparam int unsigned OSC_PER_TICK = (OSC_HZ / 1_000) * BASE_TICK_US / 1_000;
    localparam int unsigned TICK_W       = 5;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(OSC_PER_TICK - 1);

    // ********************************
    // period select: 2^sel ms, 1 ms .. 256 s
    // ********************************
    localparam int unsigned PSEL_W     = 5;
    localparam logic [PSEL_W-1:0] PSEL_MAX = 5'h12;
    localparam logic [PSEL_W-1:0] PSEL_RST = 5'h0B;
    localparam int unsigned CNT_W      = 19;

    // ********************************
    // enable configuration field
    // ********************************
    typedef enum logic [1:0] {
        SAWD_MODE_OFF   = 2'h0,
        SAWD_MODE_SOFT  = 2'h1,
        SAWD_MODE_AWAKE = 2'h2,
        SAWD_MODE_ON    = 2'h3
    } sawd_mode_t;

    // ********************************
    // register map (byte addresses)
    // ********************************
    localparam int unsigned ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_CTRL  = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STAT  = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_MASK  = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h00C;

    // control fields
    localparam int unsigned CTRL_ON_BIT = 0;
    localparam int unsigned CTRL_PS_LSB = 1;
    localparam int unsigned CTRL_PS_MSB = 5;

    // status / mask fields
    localparam int unsigned STS_W      = 3;
    localparam int unsigned STS_TO_BIT = 0;
    localparam int unsigned STS_PD_BIT = 1;
    localparam int unsigned STS_RW_BIT = 2;
    localparam logic [STS_W-1:0] MASK_RST = 3'h0;

endpackage

// >>> design/sawd_tick.sv
// Purpose: turns slow oscillator edges into the nominal 1 ms base tick
// Assumes: osc_edge is a one-cycle pulse already synchronised to clk
// Notes:   clear restarts the partial tick so a cleared watchdog starts clean
`timescale 1ns/1ps
module sawd_tick
    import sawd_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // control
    input  wire logic              osc_edge,
    input  wire logic              clr,
    // tick out
    output      logic              tick
);

    typedef struct packed {
        logic [TICK_W-1:0] div;
        logic              tick;
    } sawd_tick_t;

    sawd_tick_t st_q;
    sawd_tick_t st_d;

    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (clr) begin
            st_d.div = '0;
        end else if (osc_edge) begin
            if (st_q.div == TICK_LAST) begin
                st_d.div  = '0;
                st_d.tick = 1'b1;
            end else begin
                st_d.div = st_q.div + TICK_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

endmodule

// >>> design/sawd_top.sv
// Purpose: sleep-aware watchdog with APB registers and event interrupt
// Assumes: core signals (sleep, clear, fail, start-up) are on pclk
// Notes:   slow oscillator is sampled, not used as a clock
`timescale 1ns/1ps

// Behaviour
// - the counter advances on 1 ms ticks built from slow oscillator edges.
// - mode 11 keeps the watchdog running awake and asleep.
// - mode 10 runs it awake and stops it in sleep.
// - mode 01 lets the software enable bit alone decide.
// - the period is 2^sel ms up to 256 s, defaulting to 2 s after reset.
// - reset, clear instruction, sleep entry or exit, osc failure, disable and start-up timer clear it.
// - if still enabled in sleep it counts again from zero after the entry clear.
// - on wake it stays clear while the start-up timer runs, else it clears once.
// - the oscillator divider selection never touches the counter.
// - a timeout in sleep wakes the device rather than resetting it.
// - a timeout updates the timeout, power-down and watchdog-reset flags.
module sawd_top
    import sawd_pkg::*;
(
    // apb slave
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [sawd_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]              pwdata,
    output      logic [31:0]              prdata,
    output      logic                     pready,
    output      logic                     pslverr,
    // configuration and core state
    input  wire logic [1:0]               wdog_mode_cfg,
    input  wire logic                     sleep_state,
    input  wire logic                     wdog_clear_instr,
    input  wire logic                     osc_fail,
    input  wire logic                     osc_startup_timer,
    // slow oscillator pin
    input  wire logic                     slow_internal_osc,
    // results
    output      logic                     wdog_reset_req,
    output      logic                     wdog_wake,
    output      logic                     irq
);

    import sawd_pkg::*;

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic              osc_s1;
        logic              osc_s2;
        logic              osc_s3;
        logic              sleep_q;
        logic              soft_on;
        logic [PSEL_W-1:0] period_sel;
        logic [CNT_W-1:0]  cnt;
        logic [STS_W-1:0]  sts;
        logic [STS_W-1:0]  mask;
        logic              rst_req;
        logic              wake;
        logic              irq;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } sawd_state_t;

    localparam sawd_state_t ST_RST = '{
        osc_s1:     1'b0,
        osc_s2:     1'b0,
        osc_s3:     1'b0,
        sleep_q:    1'b0,
        soft_on:    1'b0,
        period_sel: PSEL_RST,
        cnt:        '0,
        sts:        '0,
        mask:       MASK_RST,
        rst_req:    1'b0,
        wake:       1'b0,
        irq:        1'b0,
        pready:     1'b0,
        pslverr:    1'b0,
        prdata:     32'h0000_0000
    };

    sawd_state_t st_q;
    sawd_state_t st_d;

    logic              osc_edge;
    logic              tick;
    logic              active;
    logic              clr_cnt;
    logic              sleep_edge;
    logic [PSEL_W-1:0] sel_eff;
    logic [CNT_W-1:0]  limit;
    logic              timeout;
    logic              acc;
    logic              setup;
    logic              hit_ctrl;
    logic              hit_stat;
    logic              hit_mask;
    logic              hit_cnt;
    logic [STS_W-1:0]  sts_set;
    logic [STS_W-1:0]  sts_clr;

    // ********************************
    // time base
    // ********************************
    // the second and third stages feed the rising-edge detector
    assign osc_edge = st_q.osc_s2 & ~st_q.osc_s3;

    sawd_tick u_tick (
        .clk      (pclk),
        .rst_n    (presetn),
        .osc_edge (osc_edge),
        .clr      (clr_cnt),
        .tick     (tick)
    );

    // ********************************
    // mode and clearing
    // ********************************
    always_comb begin
        unique case (sawd_mode_t'(wdog_mode_cfg))
            SAWD_MODE_ON:    active = 1'b1;
            SAWD_MODE_AWAKE: active = ~sleep_state;
            SAWD_MODE_SOFT:  active = st_q.soft_on;
            SAWD_MODE_OFF:   active = 1'b0;
        endcase
    end

    assign sleep_edge = sleep_state ^ st_q.sleep_q;

    // start-up timer input is only raised for crystal clocks,
    // so a wake without it clears for the edge cycle only
    assign clr_cnt = ~active
                   | wdog_clear_instr
                   | sleep_edge
                   | osc_fail
                   | osc_startup_timer
                   | timeout;
    // divider selection has no port here on purpose

    // ********************************
    // period compare
    // ********************************
    assign sel_eff = (st_q.period_sel > PSEL_MAX) ? PSEL_MAX : st_q.period_sel;
    assign limit   = (CNT_W'(1) << sel_eff) - CNT_W'(1);

    // last tick of the period ends it; cleared cycles never time out
    assign timeout = active & tick & (st_q.cnt == limit)
                   & ~wdog_clear_instr & ~sleep_edge
                   & ~osc_fail & ~osc_startup_timer;

    // ********************************
    // apb decode
    // ********************************
    assign setup    = psel & ~penable & ~st_q.pready;
    assign acc      = psel & penable & st_q.pready;
    assign hit_ctrl = (paddr == OFS_CTRL);
    assign hit_stat = (paddr == OFS_STAT);
    assign hit_mask = (paddr == OFS_MASK);
    assign hit_cnt  = (paddr == OFS_COUNT);

    // ********************************
    // event flags
    // ********************************
    always_comb begin
        sts_set             = '0;
        sts_set[STS_TO_BIT] = timeout;
        sts_set[STS_PD_BIT] = timeout & sleep_state;
        sts_set[STS_RW_BIT] = timeout & ~sleep_state;
        // clear only what the read returned: an event that lands after
        // the setup edge was never reported and must survive the access
        sts_clr             = (acc & ~pwrite & hit_stat) ? st_q.prdata[STS_W-1:0] : '0;
    end

    // ********************************
    // next state
    // ********************************
    always_comb begin
        st_d         = st_q;
        st_d.osc_s1  = slow_internal_osc;
        st_d.osc_s2  = st_q.osc_s1;
        st_d.osc_s3  = st_q.osc_s2;
        st_d.sleep_q = sleep_state;

        // counter: cleared, else one step per base tick
        if (clr_cnt) begin
            st_d.cnt = '0;
        end else if (tick) begin
            st_d.cnt = st_q.cnt + CNT_W'(1);
        end

        // a timeout asleep wakes, awake it resets
        st_d.wake    = timeout & sleep_state;
        st_d.rst_req = timeout & ~sleep_state;

        // set wins over read-clear
        st_d.sts = (st_q.sts & ~sts_clr) | sts_set;

        // zero-wait slave: answer prepared in the setup cycle
        st_d.pready  = setup;
        st_d.pslverr = 1'b0;
        st_d.prdata  = '0;
        if (setup) begin
            st_d.pslverr = ~(hit_ctrl | hit_stat | hit_mask | hit_cnt);
            if (!pwrite) begin
                if (hit_ctrl) begin
                    st_d.prdata[CTRL_ON_BIT]             = st_q.soft_on;
                    st_d.prdata[CTRL_PS_MSB:CTRL_PS_LSB] = st_q.period_sel;
                end
                if (hit_stat) begin
                    st_d.prdata[STS_W-1:0] = st_q.sts;
                end
                if (hit_mask) begin
                    st_d.prdata[STS_W-1:0] = st_q.mask;
                end
                if (hit_cnt) begin
                    st_d.prdata[CNT_W-1:0] = st_q.cnt;
                end
            end
        end

        // writes land at the completing edge only
        if (acc & pwrite) begin
            if (hit_ctrl) begin
                st_d.soft_on    = pwdata[CTRL_ON_BIT];
                st_d.period_sel = pwdata[CTRL_PS_MSB:CTRL_PS_LSB];
            end
            if (hit_mask) begin
                st_d.mask = pwdata[STS_W-1:0];
            end
        end

        st_d.irq = |(st_d.sts & st_d.mask);
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign prdata         = st_q.prdata;
    assign pready         = st_q.pready;
    assign pslverr        = st_q.pslverr;
    assign wdog_reset_req = st_q.rst_req;
    assign wdog_wake      = st_q.wake;
    assign irq            = st_q.irq;

endmodule

// >>> tb/sawd_top_props.sv
// Purpose: port-level checks of the sleep-aware watchdog
// Assumes: single pclk domain, presetn async active low
// Notes:   holds are judged over three cycles to cover the pulse latency
`timescale 1ns/1ps
module sawd_chk
    import sawd_pkg::*;
(
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // core state
    input wire logic [1:0] wdog_mode_cfg,
    input wire logic       sleep_state,
    input wire logic       wdog_clear_instr,
    input wire logic       osc_fail,
    input wire logic       osc_startup_timer,
    // results
    input wire logic       wdog_reset_req,
    input wire logic       wdog_wake
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_off_quiet: assert property (wdog_mode_cfg == 2'h0 && $past(wdog_mode_cfg) == 2'h0
        |-> !wdog_reset_req && !wdog_wake) else $error("watchdog fired while off");
    a_sleep_no_reset: assert property (sleep_state [*3] |-> !wdog_reset_req)
        else $error("reset request during sleep");
    a_awake_no_wake: assert property (!sleep_state [*3] |-> !wdog_wake)
        else $error("wake pulse while awake");
    a_mode10_sleep: assert property ((sleep_state && wdog_mode_cfg == 2'h2) [*3] |-> !wdog_wake)
        else $error("awake-only mode ran in sleep");
    a_clear_holds: assert property (wdog_clear_instr [*3] |-> !wdog_reset_req && !wdog_wake)
        else $error("timeout while clear held");
    a_fail_holds: assert property ($past(osc_fail) && osc_fail |=> !wdog_reset_req && !wdog_wake)
        else $error("timeout during oscillator failure");
    a_startup_holds: assert property (osc_startup_timer [*3] |-> !wdog_reset_req && !wdog_wake)
        else $error("timeout while start-up timer runs");
    a_pulse_single: assert property (wdog_reset_req |=> !wdog_reset_req [*8])
        else $error("reset request not a single pulse");
endmodule

// >>> tb/sawd_top_bench.sv
// Purpose: self-checking bench of the sleep-aware watchdog
// Assumes: slow oscillator driven fast, 4 pclk a period
// Notes:   waits are in ticks of 124 pclk, margins of half a tick
`timescale 1ns/1ps
module sawd_top_bench;
    import sawd_pkg::*;
    localparam int TK = 124;
    logic              pclk, presetn, psel, penable, pwrite, er, sw;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd, ex;
    logic              pready, pslverr, wdog_reset_req, wdog_wake, irq, sleep_state;
    logic [1:0]        wdog_mode_cfg, oc;
    logic [2:0]        hold, mk;
    logic [4:0]        sel;
    int                n_errors, checked, n_rst, n_wake, b_rst, b_wake;

    sawd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdog_mode_cfg(wdog_mode_cfg), .sleep_state(sleep_state), .wdog_clear_instr(hold[0]),
        .osc_fail(hold[1]), .osc_startup_timer(hold[2]), .slow_internal_osc(oc[1]),
        .wdog_reset_req(wdog_reset_req), .wdog_wake(wdog_wake), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) oc <= presetn ? oc + 2'h1 : 2'h0;
    // pulse tallies, so both result pulses are seen to happen, not only bounded
    always @(posedge pclk) begin
        n_rst  <= n_rst + int'(wdog_reset_req);
        n_wake <= n_wake + int'(wdog_wake);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one transfer, held until pready is sampled high; an idle edge follows
    // so a following call never reassigns psel in the same time step
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    function automatic logic act(input logic [1:0] m, input logic s, input logic sl);
        return m == 2'h3 || (m == 2'h2 && !sl) || (m == 2'h1 && s);
    endfunction

    task automatic test_done();
        $display("checks=%0d errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        sleep_state = 1'b0; hold = 3'h0; wdog_mode_cfg = 2'h0; n_errors = 0; checked = 0;
        rd = $urandom(32'h6130);
        cyc(4);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0); chk(rd, 32'h16);
        apb(1'b0, OFS_STAT, 32'h0); chk(rd, 32'h0);
        apb(1'b0, OFS_COUNT, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 12'hFF0, 32'h0); chk({rd[30:0], er}, 32'h1);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            sw = 1'($urandom);
            mk = 3'($urandom);
            wdog_mode_cfg <= 2'(i >> 1);
            sleep_state <= i[0];
            apb(1'b1, OFS_MASK, {29'h0, mk});
            apb(1'b1, OFS_CTRL, {31'h0, sw});
            apb(1'b0, OFS_STAT, 32'h0);
            b_rst = n_rst;
            b_wake = n_wake;
            cyc(3 * TK);
            ex = act(wdog_mode_cfg, sw, sleep_state) ? {29'h0, !sleep_state, sleep_state, 1'b1} : 32'h0;
            chk(irq, |(ex[2:0] & mk));
            chk(n_wake != b_wake, ex[1]);
            chk(n_rst != b_rst, ex[2]);
            apb(1'b0, OFS_STAT, 32'h0); chk(rd, ex);
        end
        $display("mode table done");
        wdog_mode_cfg <= 2'h3;
        sleep_state <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            hold <= 3'h1 << k;
            cyc(2);
            apb(1'b0, OFS_STAT, 32'h0);
            cyc(3 * TK);
            apb(1'b0, OFS_STAT, 32'h0); chk(rd, 32'h0);
            cyc(1);
            chk(irq, 1'b0);
        end
        hold <= 3'h0;
        $display("clear holds done");
        repeat (3) begin
            sel = 5'($urandom_range(1, 3));
            apb(1'b1, OFS_CTRL, {26'h0, sel, 1'b0});
            hold <= 3'h1;
            cyc(1);
            b_rst = n_rst;
            hold <= 3'h0;
            cyc(((1 << sel) * 2 - 1) * TK / 2);
            apb(1'b0, OFS_COUNT, 32'h0); chk(rd, (32'h1 << sel) - 32'h1);
            apb(1'b0, OFS_STAT, 32'h0); chk(rd, 32'h0);
            cyc(TK);
            apb(1'b0, OFS_STAT, 32'h0); chk(rd, 32'h5);
            chk(n_rst - b_rst, 32'h1);
        end
        $display("period select done");
        test_done();
    end

    initial begin
        #(50 * 20000);
        n_errors++;
        test_done();
    end
endmodule

bind sawd_top sawd_chk chk_u (.pclk(pclk), .presetn(presetn), .wdog_mode_cfg(wdog_mode_cfg),
    .sleep_state(sleep_state), .wdog_clear_instr(wdog_clear_instr), .osc_fail(osc_fail),
    .osc_startup_timer(osc_startup_timer), .wdog_reset_req(wdog_reset_req), .wdog_wake(wdog_wake));
